// ==== bay_status_pkg.sv ====
package bay_status_pkg;

  // ---------------------------------------------------------------
  // Link framing
  // ---------------------------------------------------------------
  localparam int NUM_LINKS = 2;
  localparam int BAYS_PER_LINK = 4;
  localparam int NUM_BAYS = 8;
  localparam int BITS_PER_BAY = 3;
  localparam int FRAME_BITS = 12;
  localparam logic [3:0] FRAME_LEN = 4'hc;
  localparam logic [3:0] FRAME_LAST = 4'hb;
  // Bit order of one bay inside a frame
  localparam int BIT_ACT = 0;
  localparam int BIT_LOC = 1;
  localparam int BIT_ERR = 2;

  // ---------------------------------------------------------------
  // Blink timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 200_000_000;
  localparam int REBUILD_BLINK_HZ = 1;
  localparam int IDENT_BLINK_HZ = 2;
  localparam int ACT_BLINK_HZ = 4;
  // Phase counter steps at twice the fastest blink rate
  localparam int TICK_CYCLES = CLK_FREQ_HZ / (2 * ACT_BLINK_HZ);
  localparam int PH_ACT = 0;
  localparam int PH_IDENT = 1;
  localparam int PH_REBUILD = 2;

  // ---------------------------------------------------------------
  // Management link
  // ---------------------------------------------------------------
  localparam logic [4:0] I2C_ADDR_BASE = 5'h0c;
  localparam logic [7:0] REG_PRESENT = 8'h00;
  localparam logic [7:0] REG_FAULT = 8'h01;
  localparam logic [7:0] REG_IDENT = 8'h02;
  localparam logic [7:0] REG_REBUILD = 8'h03;
  localparam logic [7:0] REG_CHANGE = 8'h04;
  localparam logic [7:0] REG_MODE = 8'h05;
  localparam int CHG_PRESENT = 0;
  localparam int CHG_FAULT = 1;
  localparam int CHG_REBUILD = 2;

  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_WRITE, ST_READ} i2c_state_type;

endpackage

// ==== bit_sync.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Two-flop synchroniser; first stage feeds only the second
// ---------------------------------------------------------------
module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  // No reset: settles within two edges, and must not block reset itself
  always_ff @(posedge clk) begin
    meta_q <= d;
    q <= meta_q;
  end
endmodule

// ==== sgpio_rx.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Serial GPIO frame receiver, runs on the link clock
// ---------------------------------------------------------------
module sgpio_rx (
  input wire logic link_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic data,
  output logic [bay_status_pkg::FRAME_BITS-1:0] frame_q,
  output logic frame_tgl_q
);
  import bay_status_pkg::*;

  logic link_rst;
  logic [3:0] cnt_q, cnt_d, idx;
  logic [FRAME_BITS-1:0] sh_q, sh_d, frame_d;
  logic tgl_d;

  // Reset brought over into the link domain
  bit_sync #(.WIDTH(1)) u_rst_sync (.clk(link_clk), .d(rst), .q(link_rst));

  // Load marks bit 0; bits past the last bay are dropped
  always_comb begin
    idx = load ? 4'h0 : cnt_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    frame_d = frame_q;
    tgl_d = frame_tgl_q;
    if (idx < FRAME_LEN) begin
      sh_d[idx] = data;
      cnt_d = idx + 4'h1;
      // Whole frame handed over by toggle; word stays put a full frame
      if (idx == FRAME_LAST) begin
        frame_d = sh_d;
        tgl_d = ~frame_tgl_q;
      end
    end
  end

  // Counter parks at the end until the next load
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      cnt_q <= FRAME_LEN;
      sh_q <= '0;
      frame_q <= '0;
      frame_tgl_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      frame_q <= frame_d;
      frame_tgl_q <= tgl_d;
    end
  end

  a_frame_start: assert property (@(posedge link_clk) disable iff (link_rst) load |=> cnt_q == 4'h1)
    else $error("frame load did not restart bit count");
  a_frame_done: assert property (@(posedge link_clk) disable iff (link_rst)
    (cnt_q == FRAME_LAST && !load) |=> frame_tgl_q != $past(frame_tgl_q))
    else $error("completed frame not handed over");
endmodule

// ==== bay_status_top.sv ====
`timescale 1ns/1ps
// Operation
// - Two independent serial GPIO links, each framed by its own clock and load.
// - Received bits light the bay LEDs and feed readable fault, identify, rebuild bits.
// - Presence, fault and rebuild readable over I2C; change flags aid event logging.
// - I2C link without platform management message protocol.
// - Slave address built from two board address bits, normally strapped.
// - Green LED blinks while the drive is active.
// - Amber steady on fault, 1 Hz blink on rebuild, 2 Hz blink on identify.
// - Both LEDs dark when no activity, fault, rebuild or identify condition.
// - No drive activity is sent toward the front panel.
// - No per-bay fault is sent toward the front panel.
module bay_status_top #(
  parameter int unsigned TICK_CYC = bay_status_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [bay_status_pkg::NUM_LINKS-1:0] sgpio_clock,
  input wire logic [bay_status_pkg::NUM_LINKS-1:0] sgpio_load,
  input wire logic [bay_status_pkg::NUM_LINKS-1:0] sgpio_dataout,
  output logic [bay_status_pkg::NUM_LINKS-1:0] sgpio_datain,
  input wire logic [bay_status_pkg::NUM_BAYS-1:0] drive_present,
  input wire logic host_port_led_enable_jumper,
  input wire logic board_address_bit0,
  input wire logic board_address_bit1,
  input wire logic i2c_scl_in,
  input wire logic i2c_sda_in,
  output logic i2c_sda_out,
  output logic i2c_sda_oe,
  output logic [bay_status_pkg::NUM_BAYS-1:0] led_green_n_q,
  output logic [bay_status_pkg::NUM_BAYS-1:0] led_amber_n_q,
  output logic jumper_enabled
);
  import bay_status_pkg::*;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Picks one bay field out of the joined frames
  function automatic logic bay_bit(input logic [NUM_LINKS*FRAME_BITS-1:0] all, input int bay, input int field);
    return all[bay * BITS_PER_BAY + field];
  endfunction

  // ---------------------------------------------------------------
  // Link receivers and crossing
  // ---------------------------------------------------------------
  logic [FRAME_BITS-1:0] rx_frame [NUM_LINKS];
  logic [FRAME_BITS-1:0] word_q [NUM_LINKS];
  logic [FRAME_BITS-1:0] word_d [NUM_LINKS];
  logic [NUM_LINKS-1:0] rx_tgl, tgl_s, seen_q, seen_d;
  logic [NUM_LINKS*FRAME_BITS-1:0] all_frames;

  // Device reports nothing back on the return line
  assign sgpio_datain = '0;

  generate
    for (genvar l = 0; l < NUM_LINKS; l++) begin : g_link
      sgpio_rx u_rx (
        .link_clk(sgpio_clock[l]),
        .rst(rst),
        .load(sgpio_load[l]),
        .data(sgpio_dataout[l]),
        .frame_q(rx_frame[l]),
        .frame_tgl_q(rx_tgl[l])
      );
      bit_sync #(.WIDTH(1)) u_tgl_sync (.clk(clk), .d(rx_tgl[l]), .q(tgl_s[l]));

      // Word is stable for a whole frame, far longer than the sync delay
      always_comb begin
        seen_d[l] = tgl_s[l];
        word_d[l] = (tgl_s[l] != seen_q[l]) ? rx_frame[l] : word_q[l];
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          seen_q[l] <= 1'b0;
          word_q[l] <= '0;
        end else begin
          seen_q[l] <= seen_d[l];
          word_q[l] <= word_d[l];
        end
      end
      assign all_frames[l*FRAME_BITS +: FRAME_BITS] = word_q[l];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [NUM_BAYS-1:0] present_s;
  logic [1:0] addr_s, i2c_s;
  logic jumper_s;

  bit_sync #(.WIDTH(NUM_BAYS)) u_pres_sync (.clk(clk), .d(drive_present), .q(present_s));
  bit_sync #(.WIDTH(2)) u_addr_sync (.clk(clk), .d({board_address_bit1, board_address_bit0}), .q(addr_s));
  bit_sync #(.WIDTH(1)) u_jmp_sync (.clk(clk), .d(host_port_led_enable_jumper), .q(jumper_s));
  bit_sync #(.WIDTH(2)) u_i2c_sync (.clk(clk), .d({i2c_scl_in, i2c_sda_in}), .q(i2c_s));

  // Pin 2 pulled up through pins 1-2 means enabled
  assign jumper_enabled = jumper_s;

  // ---------------------------------------------------------------
  // Bay status registers
  // ---------------------------------------------------------------
  logic [NUM_BAYS-1:0] act_q, act_d, fault_q, fault_d, ident_q, ident_d;
  logic [NUM_BAYS-1:0] rebuild_q, rebuild_d, present_q;
  logic [2:0] chg_q, chg_d, chg_set;
  logic chg_clr;
  logic loc, err;

  // Locate plus error together is read as rebuild in progress
  always_comb begin
    loc = 1'b0;
    err = 1'b0;
    for (int b = 0; b < NUM_BAYS; b++) begin
      loc = bay_bit(all_frames, b, BIT_LOC);
      err = bay_bit(all_frames, b, BIT_ERR);
      act_d[b] = bay_bit(all_frames, b, BIT_ACT);
      fault_d[b] = err & ~loc;
      ident_d[b] = loc & ~err;
      rebuild_d[b] = err & loc;
    end
    chg_set[CHG_PRESENT] = present_s != present_q;
    chg_set[CHG_FAULT] = fault_d != fault_q;
    chg_set[CHG_REBUILD] = rebuild_d != rebuild_q;
    // A change in the read cycle survives the clear
    chg_d = (chg_q & ~{3{chg_clr}}) | chg_set;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      act_q <= '0;
      fault_q <= '0;
      ident_q <= '0;
      rebuild_q <= '0;
      present_q <= '0;
      chg_q <= '0;
    end else begin
      act_q <= act_d;
      fault_q <= fault_d;
      ident_q <= ident_d;
      rebuild_q <= rebuild_d;
      present_q <= present_s;
      chg_q <= chg_d;
    end
  end

  // ---------------------------------------------------------------
  // Blink generator
  // ---------------------------------------------------------------
  logic [31:0] div_q, div_d;
  logic [2:0] phase_q, phase_d;
  logic tick;

  // Each phase bit is a square wave, so duty is exactly half
  always_comb begin
    tick = div_q == TICK_CYC - 32'h1;
    div_d = tick ? 32'h0 : div_q + 32'h1;
    phase_d = tick ? phase_q + 3'h1 : phase_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= '0;
      phase_q <= '0;
    end else begin
      div_q <= div_d;
      phase_q <= phase_d;
    end
  end

  // ---------------------------------------------------------------
  // Bay LEDs (local only; nothing goes to the front panel)
  // ---------------------------------------------------------------
  logic [NUM_BAYS-1:0] green_n_d, amber_n_d;
  logic ph_act, ph_ident, ph_reb;

  assign ph_act = phase_q[PH_ACT];
  assign ph_ident = phase_q[PH_IDENT];
  assign ph_reb = phase_q[PH_REBUILD];

  // Fault first, then rebuild, then identify; idle bays stay dark
  always_comb begin
    for (int b = 0; b < NUM_BAYS; b++) begin
      green_n_d[b] = ~(act_q[b] & ph_act);
      if (fault_q[b]) begin
        amber_n_d[b] = 1'b0;
      end else if (rebuild_q[b]) begin
        amber_n_d[b] = ~ph_reb;
      end else if (ident_q[b]) begin
        amber_n_d[b] = ~ph_ident;
      end else begin
        amber_n_d[b] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      led_green_n_q <= '1;
      led_amber_n_q <= '1;
    end else begin
      led_green_n_q <= green_n_d;
      led_amber_n_q <= amber_n_d;
    end
  end

  // ---------------------------------------------------------------
  // I2C slave (plain register reads, no message framing)
  // ---------------------------------------------------------------
  i2c_state_type st_q, st_d;
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] rx_q, rx_d, tx_q, tx_d, ptr_q, ptr_d, rd_idx, rd_val;
  logic scl_p_q, sda_p_q, first_q, first_d, rw_q, rw_d;
  logic nack_q, nack_d, oe_q, oe_d;
  logic scl_s, sda_s, start, stop, rise, fall, load_tx;
  logic [6:0] my_addr;

  // Unmapped indices read as zero
  function automatic logic [7:0] reg_read(input logic [7:0] idx);
    case (idx)
      REG_PRESENT: return present_q;
      REG_FAULT: return fault_q;
      REG_IDENT: return ident_q;
      REG_REBUILD: return rebuild_q;
      REG_CHANGE: return {5'h00, chg_q};
      REG_MODE: return {7'h00, jumper_s};
      default: return 8'h00;
    endcase
  endfunction

  assign scl_s = i2c_s[1];
  assign sda_s = i2c_s[0];
  assign my_addr = {I2C_ADDR_BASE, addr_s};
  assign start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign rise = scl_s & ~scl_p_q;
  assign fall = ~scl_s & scl_p_q;
  assign i2c_sda_out = 1'b0;
  assign i2c_sda_oe = oe_q;

  // Shift in on rising SCL, change SDA only after falling SCL
  always_comb begin
    st_d = st_q;
    bit_cnt_d = bit_cnt_q;
    rx_d = rx_q;
    tx_d = tx_q;
    ptr_d = ptr_q;
    first_d = first_q;
    rw_d = rw_q;
    nack_d = nack_q;
    oe_d = oe_q;
    load_tx = 1'b0;
    rd_idx = (st_q == ST_READ) ? ptr_q + 8'h01 : ptr_q;
    rd_val = reg_read(rd_idx);
    if (start) begin
      st_d = ST_ADDR;
      // One below zero: the SCL fall that closes START must not count as a bit
      bit_cnt_d = 4'hf;
      oe_d = 1'b0;
      first_d = 1'b1;
    end else if (stop) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end else if (st_q != ST_IDLE) begin
      if (rise) begin
        if (bit_cnt_q < 4'h8) begin
          rx_d = {rx_q[6:0], sda_s};
        end else begin
          nack_d = sda_s;
        end
      end
      if (fall) begin
        bit_cnt_d = bit_cnt_q + 4'h1;
        case (st_q)
          ST_ADDR: begin
            if (bit_cnt_q == 4'h7) begin
              if (rx_q[7:1] == my_addr) begin
                oe_d = 1'b1;
                rw_d = rx_q[0];
              end else begin
                st_d = ST_IDLE;
              end
            end else if (bit_cnt_q == 4'h8) begin
              bit_cnt_d = 4'h0;
              st_d = rw_q ? ST_READ : ST_WRITE;
              load_tx = rw_q;
              oe_d = 1'b0;
            end
          end
          ST_WRITE: begin
            // First byte sets the index; later bytes are acked and dropped
            if (bit_cnt_q == 4'h7) begin
              oe_d = 1'b1;
              first_d = 1'b0;
              if (first_q) begin
                ptr_d = rx_q;
              end
            end else if (bit_cnt_q == 4'h8) begin
              oe_d = 1'b0;
              bit_cnt_d = 4'h0;
            end
          end
          ST_READ: begin
            if (bit_cnt_q < 4'h7) begin
              tx_d = {tx_q[6:0], 1'b0};
              oe_d = ~tx_q[6];
            end else if (bit_cnt_q == 4'h7) begin
              oe_d = 1'b0;
            end else begin
              bit_cnt_d = 4'h0;
              if (nack_q) begin
                st_d = ST_IDLE;
              end else begin
                load_tx = 1'b1;
                ptr_d = rd_idx;
              end
            end
          end
          default: st_d = ST_IDLE;
        endcase
        if (load_tx) begin
          tx_d = rd_val;
          oe_d = ~rd_val[7];
        end
      end
    end
    chg_clr = load_tx && rd_idx == REG_CHANGE;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= ST_IDLE;
      bit_cnt_q <= '0;
      rx_q <= '0;
      tx_q <= '0;
      ptr_q <= '0;
      first_q <= 1'b0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      oe_q <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      st_q <= st_d;
      bit_cnt_q <= bit_cnt_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      ptr_q <= ptr_d;
      first_q <= first_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
      oe_q <= oe_d;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_fault_amber: assert property (fault_q != '0 |=> (led_amber_n_q & $past(fault_q)) == '0)
    else $error("faulted bay amber not steadily lit");
  a_dark_idle: assert property (1 |=> ((led_amber_n_q & led_green_n_q)
    | $past(act_q | fault_q | rebuild_q | ident_q)) == '1)
    else $error("idle bay LED lit");
  a_rebuild_blink: assert property (1 |=> ((led_amber_n_q ^ {NUM_BAYS{~$past(ph_reb)}})
    & $past(rebuild_q & ~fault_q)) == '0)
    else $error("rebuild amber not on slow phase");
  a_ident_blink: assert property (1 |=> ((led_amber_n_q ^ {NUM_BAYS{~$past(ph_ident)}})
    & $past(ident_q & ~fault_q & ~rebuild_q)) == '0)
    else $error("identify amber not on fast phase");
  a_green_blink: assert property (1 |=> led_green_n_q == ~($past(act_q) & {NUM_BAYS{$past(ph_act)}}))
    else $error("green LED not following activity blink");
  a_phase_step: assert property (tick |=> phase_q == $past(phase_q) + 3'h1 && div_q == 32'h0)
    else $error("blink phase did not step on tick");
  a_phase_hold: assert property (!tick |=> $stable(phase_q))
    else $error("blink phase moved between ticks");
  a_fault_excl: assert property ((fault_q & (rebuild_q | ident_q)) == '0)
    else $error("fault coexists with rebuild or identify");
  a_addr_ack: assert property ((st_q == ST_ADDR && fall && !start && !stop
    && bit_cnt_q == 4'h7 && rx_q[7:1] == my_addr) |=> oe_q && rw_q == $past(rx_q[0]))
    else $error("own address not acknowledged");
  a_change_set: assert property ((present_s != present_q) |=> chg_q[CHG_PRESENT])
    else $error("presence change not flagged");
endmodule

// ==== sgpio_host.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Host serial GPIO controller, one clock/load/data triple per link
// ---------------------------------------------------------------
module sgpio_host (
  input wire logic host_enable,
  output logic [1:0] sgpio_clock,
  output logic [1:0] sgpio_load,
  output logic [1:0] sgpio_dataout
);
  // Idle state: clocks parked low, data lines not holding a frame value
  initial begin
    sgpio_clock = 2'h0;
    sgpio_load = 2'h0;
    sgpio_dataout = 2'h2;
  end

  // Sends n bits LSB first; clock runs only while bits go out
  task automatic send_bits(input int link, input logic [11:0] bits, input int n, input logic framed);
    if (!host_enable) begin
      return;
    end
    #7;
    for (int i = 0; i < n; i++) begin
      sgpio_load[link] = framed && (i == 0);
      sgpio_dataout[link] = bits[i];
      #24 sgpio_clock[link] = 1'b1;
      #24 sgpio_clock[link] = 1'b0;
    end
    sgpio_load[link] = 1'b0;
    // Released line shows the inverse so a stale bit cannot pass for data
    sgpio_dataout[link] = ~sgpio_dataout[link];
  endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import bay_status_pkg::*;
  logic clk, rst, jumper, scl, sda_m, oe, sda_out, jen;
  logic [1:0] sgpio_clock, sgpio_load, sgpio_dataout, sgpio_datain, strap;
  logic [7:0] present, green_n, amber_n;
  int mismatches, comparisons;
  // Open-drain data line: pulled up unless someone pulls it low
  wire sda_line = sda_m & (~oe | sda_out);

  bay_status_top #(.TICK_CYC(8)) i_bay_status_top (.clk(clk), .rst(rst), .sgpio_clock(sgpio_clock),
    .sgpio_load(sgpio_load), .sgpio_dataout(sgpio_dataout), .sgpio_datain(sgpio_datain),
    .drive_present(present), .host_port_led_enable_jumper(jumper), .board_address_bit0(strap[0]),
    .board_address_bit1(strap[1]), .i2c_scl_in(scl), .i2c_sda_in(sda_line), .i2c_sda_out(sda_out),
    .i2c_sda_oe(oe), .led_green_n_q(green_n), .led_amber_n_q(amber_n), .jumper_enabled(jen));
  sgpio_host i_sgpio_host (.host_enable(jumper), .sgpio_clock(sgpio_clock), .sgpio_load(sgpio_load),
    .sgpio_dataout(sgpio_dataout));

  // ---------------------------------------------------------------
  // Checking and ending
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Management bus master, 12 clk per SCL low and 6 per high
  // ---------------------------------------------------------------
  task automatic half();
    repeat (6) @(posedge clk);
  endtask
  task automatic start();
    half();
    sda_m <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_m <= 1'b0;
    half();
    scl <= 1'b0;
  endtask
  task automatic stop();
    half();
    sda_m <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_m <= 1'b1;
    half();
  endtask
  // Data moves a half after SCL falls, clear of the synchronised edge
  task automatic xbit(input logic b, output logic r);
    half();
    sda_m <= b;
    half();
    scl <= 1'b1;
    half();
    r = sda_line;
    scl <= 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] r, output logic ar);
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r[i]);
    end
    xbit(a, ar);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp,
    input int n = 1, input logic [7:0] exp2 = 8'h00);
    logic [7:0] r, val, val2;
    logic a1, a2, a3, a4;
    start();
    xbyte({I2C_ADDR_BASE, strap, 1'b0}, 1'b1, r, a1);
    xbyte(idx, 1'b1, r, a2);
    start();
    xbyte({I2C_ADDR_BASE, strap, 1'b1}, 1'b1, r, a3);
    // Master ack asks for the byte at the next index
    xbyte(8'hff, n == 1, val, a4);
    if (n > 1) begin
      xbyte(8'hff, 1'b1, val2, a4);
      chk(val2, exp2);
    end
    stop();
    chk({a1, a2, a3}, 3'h0);
    chk(val, exp);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Unframed link pulses let the link-side reset take hold and let go
  task automatic wake();
    fork
      i_sgpio_host.send_bits(0, 12'h000, 4, 1'b0);
      i_sgpio_host.send_bits(1, 12'h000, 4, 1'b0);
    join
  endtask
  task automatic t_reset();
    chk(amber_n, 8'hff);
    chk(green_n, 8'hff);
    chk(oe, 1'b0);
    chk(sgpio_datain, 2'h0);
  endtask
  // Link 0: bay0 error, bay1 locate, bay2 both, bay3 activity
  // Link 1: bay4 error and activity, bay6 locate
  task automatic t_status();
    present <= 8'ha5;
    i_sgpio_host.send_bits(0, 12'h394, 12, 1'b1);
    i_sgpio_host.send_bits(1, 12'h085, 12, 1'b1);
    repeat (20) @(posedge clk);
    rd_chk(REG_FAULT, 8'h11, 2, 8'h42);
    rd_chk(REG_IDENT, 8'h42);
    rd_chk(REG_REBUILD, 8'h04);
    rd_chk(REG_PRESENT, 8'ha5);
  endtask
  // Phase steps every 8 clk, so 128 clk hold whole blink periods
  task automatic t_leds();
    int ta[8], tg[8];
    int ea[8] = '{0, 8, 4, 0, 0, 0, 8, 0};
    int eg[8] = '{0, 0, 0, 16, 16, 0, 0, 0};
    logic [7:0] pa, pg;
    ta = '{default: 0};
    tg = '{default: 0};
    pa = amber_n;
    pg = green_n;
    repeat (128) begin
      @(posedge clk);
      #1;
      for (int b = 0; b < 8; b++) begin
        ta[b] += int'(amber_n[b] !== pa[b]);
        tg[b] += int'(green_n[b] !== pg[b]);
      end
      pa = amber_n;
      pg = green_n;
      chk(sgpio_datain, 2'h0);
    end
    for (int b = 0; b < 8; b++) begin
      chk(ta[b], ea[b]);
      chk(tg[b], eg[b]);
    end
    chk(amber_n & 8'hb9, 8'ha8);
    chk(green_n & 8'he7, 8'he7);
  endtask
  task automatic t_change();
    rd_chk(REG_CHANGE, 8'h07);
    rd_chk(REG_CHANGE, 8'h00);
    present <= 8'h25;
    repeat (8) @(posedge clk);
    rd_chk(REG_CHANGE, 8'h01);
  endtask
  // Foreign address goes unanswered; a cut frame gives way to the next
  task automatic t_refuse();
    logic [7:0] r;
    logic a;
    start();
    xbyte({I2C_ADDR_BASE, ~strap, 1'b0}, 1'b1, r, a);
    stop();
    chk(a, 1'b1);
    i_sgpio_host.send_bits(0, 12'hfff, 6, 1'b1);
    i_sgpio_host.send_bits(0, 12'h020, 12, 1'b1);
    repeat (20) @(posedge clk);
    rd_chk(REG_FAULT, 8'h12);
    rd_chk(REG_IDENT, 8'h40);
    rd_chk(REG_REBUILD, 8'h00);
  endtask
  task automatic t_jumper();
    jumper <= 1'b0;
    repeat (6) @(posedge clk);
    chk(jen, 1'b0);
    rd_chk(REG_MODE, 8'h00);
    jumper <= 1'b1;
    repeat (6) @(posedge clk);
    chk(jen, 1'b1);
    rd_chk(REG_MODE, 8'h01);
  endtask

  // ---------------------------------------------------------------
  // Clock, sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    scl = 1'b1;
    sda_m = 1'b1;
    jumper = 1'b1;
    present = 8'h00;
    strap = 2'b10;
    mismatches = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    // Reset stretched until the parked link clocks have ticked
    wake();
    @(posedge clk);
    rst <= 1'b0;
    wake();
    t_reset();
    t_status();
    t_leds();
    t_change();
    t_refuse();
    t_jumper();
    conclude();
  end
  // Whole run is near 10k clk; allow some three times that
  initial begin
    #150000;
    mismatches++;
    conclude();
  end
endmodule
